// *** hdl/gp_timer_block.sv ***
// Three 16-bit general-purpose timers with shadowed compare and period,
// prescaler, quadrature clocking, 32-bit cascade and compare outputs.
// Assumes pins synchronous to mclk and a master that never waits.
//
// Decided for this implementation: the address map and the strobed register port.
module gp_timer_block (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire gpt_pkg::reg_req_t bus_req,
  output logic [15:0]            rdata,
  input  wire logic              external_timer_clock_pin,
  input  wire logic              direction_input_pin,
  input  wire logic              qep_a,
  input  wire logic              qep_b,
  output logic [2:0]             compare_output_pin,
  output logic                   adc_start
);

  // ==========================================================================
  // State
  logic [15:0]            cnt_r [3];
  logic [15:0]            cnt_nxt [3];
  logic [15:0]            cmp_sh_r [3];
  logic [15:0]            cmp_r [3];
  logic [15:0]            cmp_nxt [3];
  logic [15:0]            per_sh_r [3];
  logic [15:0]            per_r [3];
  logic [15:0]            ctrl_r [3];
  logic [15:0]            ctrl_nxt [3];
  logic [6:0]             pre_r [3];
  logic [6:0]             pre_nxt [3];
  logic [gpt_pkg::SH_W-1:0] shared_r;
  logic [2:0]             dir_r, dir_nxt;
  logic [2:0]             act_r, act_nxt;
  logic [2:0]             pin_r, pin_nxt;
  logic [2:0]             en_clr;
  logic [11:0]            ev1_r, ev_nxt, ev2_r, flags_r;
  logic                   ext_prev_r, qa_r, qb_r, adc_r, adc_nxt;
  logic [15:0]            rdata_r, rd_val;

  // ==========================================================================
  // Decoding
  function automatic logic [6:0] pre_limit(input logic [2:0] code);
    unique case (code)
      3'h0:    pre_limit = 7'h00;
      3'h1:    pre_limit = 7'h01;
      3'h2:    pre_limit = 7'h03;
      3'h3:    pre_limit = 7'h07;
      3'h4:    pre_limit = 7'h1F;
      default: pre_limit = 7'h7F;
    endcase
  endfunction

  function automatic logic [1:0] field2(input logic [15:0] v, input int lsb);
    field2 = v[lsb +: 2];
  endfunction

  wire logic [3:0] addr_m1 = bus_req.addr - gpt_pkg::OFF_TMR_BASE;
  wire logic       tmr_hit = (bus_req.addr >= gpt_pkg::OFF_TMR_BASE) &&
                             (bus_req.addr <= gpt_pkg::OFF_TMR_LAST);
  wire logic       w_sh    = bus_req.wr && bus_req.addr == gpt_pkg::OFF_SHARED;
  wire logic       w_flg   = bus_req.wr && bus_req.addr == gpt_pkg::OFF_FLAGS;
  wire logic       ext_rise = external_timer_clock_pin && !ext_prev_r;
  // Every edge on either channel is one count, so four per encoder cycle
  wire logic       qep_edge = (qep_a ^ qa_r) | (qep_b ^ qb_r); // R21
  wire logic       qep_up   = qep_a ^ qb_r;
  wire logic       casc     = field2(ctrl_r[2], gpt_pkg::CT_SRC_LSB) == gpt_pkg::SRC_CASC;
  wire logic [31:0] c32 = {cnt_r[2], cnt_r[1]};
  wire logic [31:0] p32 = {per_r[2], per_r[1]}; // R17

  logic [2:0]  w_cnt, w_cmp, w_per, w_ctl, en_w, raw_w, byp_w, din_w;
  logic [1:0]  src_w [3];
  logic [2:0]  mode_w [3];
  logic [15:0] pe_w [3];

  for (genvar g = 0; g < 3; g++) begin : g_dec
    assign w_cnt[g] = bus_req.wr && tmr_hit && addr_m1[3:2] == 2'(g) &&
                      addr_m1[1:0] == gpt_pkg::SUB_CNT;
    assign w_cmp[g] = bus_req.wr && tmr_hit && addr_m1[3:2] == 2'(g) &&
                      addr_m1[1:0] == gpt_pkg::SUB_CMP;
    assign w_per[g] = bus_req.wr && tmr_hit && addr_m1[3:2] == 2'(g) &&
                      addr_m1[1:0] == gpt_pkg::SUB_PER;
    assign w_ctl[g] = bus_req.wr && tmr_hit && addr_m1[3:2] == 2'(g) &&
                      addr_m1[1:0] == gpt_pkg::SUB_CTL;
    assign src_w[g] = field2(ctrl_r[g], gpt_pkg::CT_SRC_LSB);
    assign mode_w[g] = ctrl_r[g][gpt_pkg::CT_MODE_LSB +: 3];
    // Start from timer 1's enable bit; count resumes from the present value
    assign en_w[g] = (g != 0 && ctrl_r[g][gpt_pkg::CT_T1EN]) ?
                     ctrl_r[0][gpt_pkg::CT_EN] : ctrl_r[g][gpt_pkg::CT_EN]; // R22
    assign pe_w[g] = (g != 0 && ctrl_r[g][gpt_pkg::CT_T1PER]) ? per_r[0] : per_r[g]; // R4
    // Quadrature only on timers 2 and 3; timer 3 gets cascade ticks elsewhere
    assign raw_w[g] = src_w[g] == gpt_pkg::SRC_INT ||
                      (src_w[g] == gpt_pkg::SRC_EXT && ext_rise) ||
                      (g != 0 && src_w[g] == gpt_pkg::SRC_QEP && qep_edge);
    assign byp_w[g] = src_w[g] == gpt_pkg::SRC_QEP; // R20
    assign din_w[g] = byp_w[g] ? qep_up : direction_input_pin; // R15
  end

  // ==========================================================================
  // Counting
  always_comb begin
    logic        tick;
    logic [15:0] n;
    logic [31:0] n32;
    logic        up;
    logic        roll;
    tick = 1'b0;
    n = 16'h0000;
    n32 = 32'h0000_0000;
    up = 1'b0;
    roll = 1'b0;
    ev_nxt = 12'h000;
    en_clr = 3'b000;
    for (int i = 0; i < 3; i++) begin
      cnt_nxt[i] = cnt_r[i];
      pre_nxt[i] = pre_r[i];
      dir_nxt[i] = dir_r[i];
      act_nxt[i] = act_r[i];
      tick = 1'b0;
      n = cnt_r[i];
      if (!en_w[i]) begin
        pre_nxt[i] = 7'h00;
      end else if (mode_w[i] != gpt_pkg::MODE_STOP && raw_w[i]) begin
        if (byp_w[i] || pre_r[i] >= pre_limit(ctrl_r[i][gpt_pkg::CT_PRE_LSB +: 3])) begin
          pre_nxt[i] = 7'h00; // R3
          tick = 1'b1;
        end else begin
          pre_nxt[i] = pre_r[i] + 7'h01;
        end
      end
      if (tick) begin
        unique case (mode_w[i])
          gpt_pkg::MODE_SUP, gpt_pkg::MODE_CUP: begin
            dir_nxt[i] = 1'b1;
            n = (cnt_r[i] == pe_w[i]) ? 16'h0000 : cnt_r[i] + 16'h0001; // R6
            en_clr[i] = mode_w[i] == gpt_pkg::MODE_SUP && cnt_r[i] == pe_w[i];
          end
          gpt_pkg::MODE_DIR: begin
            dir_nxt[i] = din_w[i]; // R15
            if (din_w[i]) begin
              if (cnt_r[i] != pe_w[i]) n = cnt_r[i] + 16'h0001;
              else if (i == 1) n = 16'h0000;
            end else begin
              if (cnt_r[i] != 16'h0000) n = cnt_r[i] - 16'h0001;
              else if (i == 1) n = pe_w[i];
            end
          end
          gpt_pkg::MODE_SUD, gpt_pkg::MODE_CUD: begin
            if (dir_r[i] && cnt_r[i] >= pe_w[i]) begin
              dir_nxt[i] = 1'b0; // R6
              n = cnt_r[i] - 16'h0001;
            end else if (!dir_r[i] && cnt_r[i] == 16'h0000) begin
              dir_nxt[i] = 1'b1;
              n = cnt_r[i] + 16'h0001;
            end else begin
              n = dir_r[i] ? cnt_r[i] + 16'h0001 : cnt_r[i] - 16'h0001;
            end
            en_clr[i] = mode_w[i] == gpt_pkg::MODE_SUD && !dir_r[i] && n == 16'h0000;
          end
          default: n = cnt_r[i];
        endcase
        if (n != cnt_r[i]) begin
          ev_nxt[4*i + gpt_pkg::EV_OF] = n == gpt_pkg::CNT_MAX; // R24
          ev_nxt[4*i + gpt_pkg::EV_UF] = n == 16'h0000; // R24
          ev_nxt[4*i + gpt_pkg::EV_CMP] = n == cmp_r[i] && ctrl_r[i][gpt_pkg::CT_CMPEN]; // R5
          ev_nxt[4*i + gpt_pkg::EV_PER] = n == pe_w[i];
        end
        cnt_nxt[i] = n;
      end
    end
    // Cascade overrides timer 2 and drives timer 3 from its rollover
    if (casc) begin
      ev_nxt[11:8] = 4'h0; // R18
      ev_nxt[7:4] = 4'h0;
      cnt_nxt[1] = cnt_r[1];
      cnt_nxt[2] = cnt_r[2];
      en_clr[2:1] = 2'b00;
      pre_nxt[2] = 7'h00;
      up = din_w[1]; // R16
      if (en_w[1] && raw_w[1] &&
          (byp_w[1] || pre_r[1] >= pre_limit(ctrl_r[1][gpt_pkg::CT_PRE_LSB +: 3]))) begin
        dir_nxt[1] = up;
        dir_nxt[2] = up;
        if (up ? (c32 < p32) : (c32 != 32'h0000_0000)) begin // R19
          roll = up ? cnt_r[1] == gpt_pkg::CNT_MAX : cnt_r[1] == 16'h0000;
          cnt_nxt[1] = up ? cnt_r[1] + 16'h0001 : cnt_r[1] - 16'h0001;
          if (roll) cnt_nxt[2] = up ? cnt_r[2] + 16'h0001 : cnt_r[2] - 16'h0001; // R2 R25
          n32 = {cnt_nxt[2], cnt_nxt[1]};
          ev_nxt[4 + gpt_pkg::EV_OF] = n32 == 32'hFFFF_FFFF; // R17
          ev_nxt[4 + gpt_pkg::EV_UF] = n32 == 32'h0000_0000;
          ev_nxt[4 + gpt_pkg::EV_PER] = n32 == p32;
          ev_nxt[4 + gpt_pkg::EV_CMP] = cnt_nxt[1] == cmp_r[1] && ctrl_r[1][gpt_pkg::CT_CMPEN];
          ev_nxt[8 + gpt_pkg::EV_CMP] = roll && cnt_nxt[2] == cmp_r[2] &&
                                        ctrl_r[2][gpt_pkg::CT_CMPEN]; // R17
        end
      end
    end
    // Output state; up modes end the pulse at period, up/down at second compare
    for (int i = 0; i < 3; i++) begin
      if (!ctrl_r[i][gpt_pkg::CT_CMPEN]) begin
        act_nxt[i] = 1'b0;
      end else if (ev_nxt[4*i + gpt_pkg::EV_PER] && mode_w[i] inside {gpt_pkg::MODE_SUP,
          gpt_pkg::MODE_CUP}) begin
        act_nxt[i] = 1'b0; // R12
      end else if (ev_nxt[4*i + gpt_pkg::EV_CMP]) begin
        act_nxt[i] = (mode_w[i] inside {gpt_pkg::MODE_SUP, gpt_pkg::MODE_CUP}) ?
                     1'b1 : !act_r[i]; // R12
      end
      if (w_cnt[i]) begin
        cnt_nxt[i] = bus_req.wdata;
        ev_nxt[4*i +: 4] = 4'h0;
      end
    end
  end

  // ==========================================================================
  // Shadow reload, control, outputs
  always_comb begin
    logic [15:0] sh;
    sh = 16'h0000;
    adc_nxt = 1'b0;
    for (int i = 0; i < 3; i++) begin
      sh = w_cmp[i] ? bus_req.wdata : cmp_sh_r[i]; // R7
      cmp_nxt[i] = cmp_r[i];
      if (!ctrl_r[i][gpt_pkg::CT_CMPEN]) begin
        cmp_nxt[i] = sh; // R10
      end else begin
        unique case (field2(ctrl_r[i], gpt_pkg::CT_RLD_LSB))
          gpt_pkg::RLD_NOW: if (w_cmp[i]) cmp_nxt[i] = sh; // R8
          gpt_pkg::RLD_ZERO_PER:
            if (cnt_r[i] == 16'h0000 || cnt_r[i] == pe_w[i]) cmp_nxt[i] = cmp_sh_r[i]; // R8
          default: if (cnt_r[i] == 16'h0000) cmp_nxt[i] = cmp_sh_r[i]; // R8
        endcase
      end
      ctrl_nxt[i] = w_ctl[i] ? bus_req.wdata : ctrl_r[i];
      if (en_clr[i] && !w_ctl[i]) ctrl_nxt[i][gpt_pkg::CT_EN] = 1'b0;
      // Outputs idle low while the shared output enable is off
      unique case (field2(16'(shared_r), gpt_pkg::SH_POL_LSB + 2*i))
        gpt_pkg::POL_FLOW:  pin_nxt[i] = 1'b0; // R13
        gpt_pkg::POL_FHIGH: pin_nxt[i] = shared_r[gpt_pkg::SH_CMPOE]; // R13
        gpt_pkg::POL_AHIGH: pin_nxt[i] = shared_r[gpt_pkg::SH_CMPOE] && act_nxt[i];
        default:            pin_nxt[i] = shared_r[gpt_pkg::SH_CMPOE] && !act_nxt[i];
      endcase
      unique case (field2(16'(shared_r), gpt_pkg::SH_ADC_LSB + 2*i))
        gpt_pkg::ADC_UF:  adc_nxt = adc_nxt | ev2_r[4*i + gpt_pkg::EV_UF];
        gpt_pkg::ADC_CMP: adc_nxt = adc_nxt | ev2_r[4*i + gpt_pkg::EV_CMP]; // R5
        gpt_pkg::ADC_PER: adc_nxt = adc_nxt | ev2_r[4*i + gpt_pkg::EV_PER];
        default:          adc_nxt = adc_nxt;
      endcase
    end
  end

  // Compare and period read back the shadow copy software last wrote
  always_comb begin
    rd_val = 16'h0000;
    if (bus_req.addr == gpt_pkg::OFF_SHARED) begin
      rd_val = {dir_r, shared_r}; // R14
    end else if (bus_req.addr == gpt_pkg::OFF_FLAGS) begin
      rd_val = {4'h0, flags_r};
    end else if (tmr_hit) begin
      unique case (addr_m1[1:0])
        gpt_pkg::SUB_CNT: rd_val = cnt_r[addr_m1[3:2]];
        gpt_pkg::SUB_CMP: rd_val = cmp_sh_r[addr_m1[3:2]];
        gpt_pkg::SUB_PER: rd_val = per_sh_r[addr_m1[3:2]];
        default:          rd_val = ctrl_r[addr_m1[3:2]];
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 3; i++) begin
        cnt_r[i] <= gpt_pkg::REG_RST;
        cmp_sh_r[i] <= gpt_pkg::REG_RST;
        cmp_r[i] <= gpt_pkg::REG_RST;
        per_sh_r[i] <= gpt_pkg::REG_RST;
        per_r[i] <= gpt_pkg::REG_RST;
        ctrl_r[i] <= gpt_pkg::REG_RST;
        pre_r[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt_r[i] <= cnt_nxt[i];
        cmp_sh_r[i] <= w_cmp[i] ? bus_req.wdata : cmp_sh_r[i]; // R7
        cmp_r[i] <= cmp_nxt[i];
        per_sh_r[i] <= w_per[i] ? bus_req.wdata : per_sh_r[i]; // R7
        per_r[i] <= (cnt_r[i] == 16'h0000) ? per_sh_r[i] : per_r[i]; // R9
        ctrl_r[i] <= ctrl_nxt[i];
        pre_r[i] <= pre_nxt[i];
      end
    end
  end

  // Two pipeline stages put every flag two clocks behind its count
  always_ff @(posedge mclk) begin
    if (srst) begin
      shared_r <= '0;
      {dir_r, act_r, pin_r} <= 9'h000;
      {ev1_r, ev2_r, flags_r} <= '0;
      {ext_prev_r, qa_r, qb_r, adc_r} <= 4'h0;
      rdata_r <= 16'h0000;
    end else begin
      shared_r <= w_sh ? bus_req.wdata[gpt_pkg::SH_W-1:0] : shared_r;
      dir_r <= dir_nxt;
      act_r <= act_nxt;
      pin_r <= pin_nxt;
      ev1_r <= ev_nxt;
      ev2_r <= ev1_r; // R23
      flags_r <= (flags_r & ~(w_flg ? bus_req.wdata[11:0] : 12'h000)) | ev2_r; // R24
      {ext_prev_r, qa_r, qb_r} <= {external_timer_clock_pin, qep_a, qep_b};
      adc_r <= adc_nxt;
      rdata_r <= bus_req.rd ? rd_val : 16'h0000;
    end
  end

  assign rdata = rdata_r;
  assign compare_output_pin = pin_r;
  assign adc_start = adc_r;

  // ==========================================================================
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  property p_cmp_flag;
    ev1_r[gpt_pkg::EV_CMP] |-> cnt_r[0] == $past(cmp_r[0]) && $past(ctrl_r[0][1])
      ##2 flags_r[gpt_pkg::EV_CMP];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag timing"); // R23

  property p_of_flag;
    ev1_r[gpt_pkg::EV_OF] && !casc |-> cnt_r[0] == 16'hFFFF ##2 flags_r[gpt_pkg::EV_OF];
  endproperty
  a_of_flag: assert property (p_of_flag) else $error("overflow flag timing"); // R24

  property p_uf_zero;
    ev1_r[gpt_pkg::EV_UF] |-> cnt_r[0] == 16'h0000;
  endproperty
  a_uf_zero: assert property (p_uf_zero) else $error("underflow not at zero"); // R24

  property p_per_load;
    cnt_r[0] == 16'h0000 |=> per_r[0] == $past(per_sh_r[0]);
  endproperty
  a_per_load: assert property (p_per_load) else $error("period not reloaded"); // R9

  property p_per_hold;
    cnt_r[0] != 16'h0000 |=> $stable(per_r[0]);
  endproperty
  a_per_hold: assert property (p_per_hold) else $error("period changed mid-count"); // R7

  property p_transp;
    w_cmp[0] && !ctrl_r[0][1] |=> cmp_r[0] == $past(bus_req.wdata);
  endproperty
  a_transp: assert property (p_transp) else $error("compare not transparent"); // R10

  property p_forced;
    shared_r[1:0] == gpt_pkg::POL_FHIGH && shared_r[6] |=> compare_output_pin[0];
  endproperty
  a_forced: assert property (p_forced) else $error("forced high missing"); // R13

  property p_dir_read;
    bus_req.rd && bus_req.addr == gpt_pkg::OFF_SHARED |=> rdata[13] == $past(dir_r[0]);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction bit readback"); // R14

  property p_cmp_gate;
    !ctrl_r[0][gpt_pkg::CT_CMPEN] |=> !act_r[0] && !ev1_r[gpt_pkg::EV_CMP];
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare acted while disabled"); // R5

  property p_up_end;
    ev1_r[gpt_pkg::EV_PER] && $past(ctrl_r[0][gpt_pkg::CT_CMPEN]) &&
      $past(mode_w[0]) == gpt_pkg::MODE_CUP |-> !act_r[0];
  endproperty
  a_up_end: assert property (p_up_end) else $error("output not ended at period"); // R12

endmodule

// *** hdl/gpt_pkg.sv ***
// Constants, register map and bus carrier of the general-purpose timer block.
// Assumes a single 100 MHz clock and a plain strobed register port.
//
// Overview of operation
// R1: Outside logic keeps the external timer clock at most a quarter of the CPU clock.
// R2: Cascaded, timer 3 counts on timer 2 rollovers.
// R3: Each control register picks one of six prescale divisions, /1 to /128.
// R4: Timers 2 and 3 may use timer 1's period instead of their own.
// R5: Compare match toggles output, may start ADC, sets flag; control bit 1 gates it.
// R6: Period match holds, clears or reverses the counter per counting mode.
// R7: Compare and period writes always land in shadow registers.
// R8: Working compare loads immediately, on zero, or on zero or period.
// R9: Working period loads from its shadow only while the counter is zero.
// R10: With compare disabled, compare writes pass straight into the working register.
// R11: Software programs the period before loading a nonzero count.
// R12: Active output asserts at first compare; returns at second compare or period match.
// R13: Forced high or low outputs take that level at once.
// R14: Shared control direction bits read 1 counting up, 0 counting down.
// R15: Directional mode: direction pin high counts up, low counts down.
// R16: Cascade: timer 2 is the low half; pair runs directional only.
// R17: Cascade: 32-bit period and wrap events; compares stay 16-bit per timer.
// R18: Cascade: timer 2 flags 32-bit period and wrap events; timer 3's masked.
// R19: Cascaded counter saturates at period going up and at zero going down.
// R20: With quadrature clocking the selected timer's prescaler is fixed at /1.
// R21: Quadrature decoder counts every edge of both channels.
// R22: Timers 2 and 3 may start from timer 1's enable, from their current count.
// R23: Compare flag sets two clocks after the match when compare is enabled.
// R24: Overflow at FFFF and underflow at 0000 set flags two clocks later.
// R25: Cascaded timer 3 steps once per timer 2 wrap in the current direction.
package gpt_pkg;

  // ==========================================================================
  // Register map (word indices)
  localparam logic [3:0] OFF_SHARED = 4'h0;
  localparam logic [3:0] OFF_TMR_BASE = 4'h1;
  localparam logic [3:0] OFF_TMR_LAST = 4'hC;
  localparam logic [3:0] OFF_FLAGS = 4'hD;
  localparam logic [1:0] SUB_CNT = 2'h0;
  localparam logic [1:0] SUB_CMP = 2'h1;
  localparam logic [1:0] SUB_PER = 2'h2;
  localparam logic [1:0] SUB_CTL = 2'h3;

  // ==========================================================================
  // Per-timer control fields
  localparam int CT_T1PER = 0;
  localparam int CT_CMPEN = 1;
  localparam int CT_RLD_LSB = 2;
  localparam int CT_SRC_LSB = 4;
  localparam int CT_EN = 6;
  localparam int CT_T1EN = 7;
  localparam int CT_PRE_LSB = 8;
  localparam int CT_MODE_LSB = 11;
  localparam logic [1:0] RLD_ZERO = 2'h0;
  localparam logic [1:0] RLD_ZERO_PER = 2'h1;
  localparam logic [1:0] RLD_NOW = 2'h2;
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_CASC = 2'h2;
  localparam logic [1:0] SRC_QEP = 2'h3;
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_SUP = 3'h1;
  localparam logic [2:0] MODE_CUP = 3'h2;
  localparam logic [2:0] MODE_DIR = 3'h3;
  localparam logic [2:0] MODE_SUD = 3'h4;
  localparam logic [2:0] MODE_CUD = 3'h5;

  // ==========================================================================
  // Shared control fields and flag layout
  localparam int SH_POL_LSB = 0;
  localparam int SH_CMPOE = 6;
  localparam int SH_ADC_LSB = 7;
  localparam int SH_W = 13;
  localparam logic [1:0] POL_FLOW = 2'h0;
  localparam logic [1:0] POL_ALOW = 2'h1;
  localparam logic [1:0] POL_AHIGH = 2'h2;
  localparam logic [1:0] POL_FHIGH = 2'h3;
  localparam logic [1:0] ADC_UF = 2'h1;
  localparam logic [1:0] ADC_CMP = 2'h2;
  localparam logic [1:0] ADC_PER = 2'h3;
  localparam int EV_OF = 0;
  localparam int EV_UF = 1;
  localparam int EV_CMP = 2;
  localparam int EV_PER = 3;

  // ==========================================================================
  // Reset values and timing
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int FLAG_DELAY_CYC = 2;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// *** verification/gpt_pin_source.sv ***
// Pin-side model: external timer clock source and quadrature encoder.
// Assumes the bench calls its tasks; pins stand still between bursts.
module gpt_pin_source (
  input  wire logic mclk,
  output logic      ext_clk,
  output logic      qa,
  output logic      qb
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Idle levels
  initial begin
    ext_clk = 1'b0;
    qa = 1'b0;
    qb = 1'b0;
  end

  // ==========================================================
  // Bursts
  // Eight mclk per period, well under a quarter of mclk
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b0;
    end
  endtask

  // Channel a leads b; one edge every four mclk
  task automatic quad_steps(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge mclk);
      if (qa == qb) qa <= ~qa;
      else qb <= ~qb;
    end
  endtask
endmodule

// *** verification/gp_timer_block_tb.sv ***
// Self-checking bench of the timer block over its register port.
// Assumes the pin source model drives the clock and encoder inputs.
module gp_timer_block_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic              mclk;
  logic              srst;
  logic              dir_pin;
  logic              ext_clk;
  logic              qa;
  logic              qb;
  logic              adc_start;
  logic [2:0]        cmp_pin;
  logic [15:0]       rdata;
  logic [15:0]       v;
  logic [15:0]       seed;
  gpt_pkg::reg_req_t bus_req;
  int                fail_count;
  int                n_compared;
  int                n_high;
  int                n_adc;

  gp_timer_block uut (
    .mclk(mclk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
    .external_timer_clock_pin(ext_clk), .direction_input_pin(dir_pin),
    .qep_a(qa), .qep_b(qb), .compare_output_pin(cmp_pin), .adc_start(adc_start)
  );
  gpt_pin_source part (.mclk(mclk), .ext_clk(ext_clk), .qa(qa), .qb(qb));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] ctl(input logic [2:0] m, input logic [2:0] p,
                                      input logic [1:0] s, input logic en, input logic ce);
    return {2'b00, m, p, 1'b0, en, s, 2'b00, ce, 1'b0};
  endfunction

  // Start and stop writes blur the span by a couple of counts
  function automatic logic near(input logic [15:0] g, input int e);
    return (int'(g) - e <= 2) && (e - int'(g) <= 2);
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req <= {a, d, 1'b0, 1'b0};
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_req <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req <= {a, 16'h0000, 1'b0, 1'b0};
    #1 d = rdata;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string nm);
    logic [15:0] g;
    rd(a, g);
    chk(nm, e, g);
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    give_verdict;
  end

  // ==========================================================
  // Scenarios
  initial begin
    srst = 1'b1;
    bus_req = '0;
    dir_pin = 1'b1;
    seed = 16'h0048;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd_chk(4'h0, 16'h0000, "shared");
    rd_chk(4'hE, 16'h0000, "unmapped");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(4'h2 + {3'h0, i[0]}, seed);
      rd_chk(4'h2 + {3'h0, i[0]}, seed, "shadow");
    end
    wr(4'h0, 16'h0043);
    @(posedge mclk);
    #1 chk("pin_high", 16'h0001, {13'h0, cmp_pin});
    wr(4'h0, 16'h0040);
    @(posedge mclk);
    #1 chk("pin_low", 16'h0000, {13'h0, cmp_pin});
    for (int c = 0; c < 6; c++) begin
      wr(4'h3, 16'hFFFF);
      wr(4'h1, 16'h0000);
      wr(4'h4, ctl(gpt_pkg::MODE_CUP, 3'(c), gpt_pkg::SRC_INT, 1'b1, 1'b0));
      repeat (250) @(posedge mclk);
      wr(4'h4, 16'h0000);
      rd(4'h1, v);
      chk("prescale", 16'h0001, {15'h0, near(v, 252 >> (c < 4 ? c : (c == 4 ? 5 : 7)))});
    end
    wr(4'h1, 16'hFFFC);
    wr(4'h4, ctl(gpt_pkg::MODE_CUP, 3'h0, gpt_pkg::SRC_INT, 1'b1, 1'b0));
    repeat (8) @(posedge mclk);
    rd(4'h0, v);
    chk("dir_up", 16'h0001, {15'h0, v[13]});
    wr(4'h4, 16'h0000);
    rd(4'hD, v);
    chk("wrap_flags", 16'h0003, v & 16'h0003);
    wr(4'hD, 16'hFFFF);
    rd_chk(4'hD, 16'h0000, "flags_clr");
    // Compare written while disabled, so it is already working
    for (int e = 0; e < 2; e++) begin
      wr(4'h1, 16'h0000);
      wr(4'h3, 16'h0040);
      wr(4'h2, 16'h0020);
      wr(4'h4, ctl(gpt_pkg::MODE_CUP, 3'h0, gpt_pkg::SRC_INT, 1'b1, e[0]));
      repeat (60) @(posedge mclk);
      wr(4'h4, 16'h0000);
      rd(4'hD, v);
      chk("cmp_flag", {13'h0, e[0], 2'b00}, v & 16'h0004);
      wr(4'hD, 16'hFFFF);
    end
    dir_pin <= 1'b0;
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0200);
    wr(4'h1, 16'h0100);
    wr(4'h4, ctl(gpt_pkg::MODE_DIR, 3'h0, gpt_pkg::SRC_INT, 1'b1, 1'b0));
    repeat (16) @(posedge mclk);
    rd(4'h0, v);
    chk("dir_down", 16'h0000, {15'h0, v[13]});
    wr(4'h4, 16'h0000);
    rd(4'h1, v);
    chk("down_cnt", 16'h0001, {15'h0, v < 16'h0100 && v > 16'h00E0});
    dir_pin <= 1'b1;
    wr(4'h5, 16'h0000);
    wr(4'h7, 16'hFFFF);
    wr(4'hB, 16'hFFFF);
    wr(4'h5, 16'hFFFA);
    wr(4'hC, ctl(gpt_pkg::MODE_DIR, 3'h0, gpt_pkg::SRC_CASC, 1'b1, 1'b0));
    wr(4'h8, ctl(gpt_pkg::MODE_DIR, 3'h0, gpt_pkg::SRC_INT, 1'b1, 1'b0));
    repeat (20) @(posedge mclk);
    wr(4'h8, 16'h0000);
    rd_chk(4'h9, 16'h0001, "casc_high");
    rd(4'hD, v);
    chk("casc_flags", 16'h0000, v & 16'h0030);
    wr(4'hC, 16'h0000);
    wr(4'h5, 16'h0064);
    wr(4'h8, ctl(gpt_pkg::MODE_DIR, 3'h7, gpt_pkg::SRC_QEP, 1'b1, 1'b0));
    part.quad_steps(8);
    repeat (4) @(posedge mclk);
    wr(4'h8, 16'h0000);
    rd_chk(4'h5, 16'h006C, "quad_cnt");
    wr(4'h1, 16'h0000);
    wr(4'h4, ctl(gpt_pkg::MODE_CUP, 3'h0, gpt_pkg::SRC_EXT, 1'b1, 1'b0));
    part.ext_pulses(10);
    wr(4'h4, 16'h0000);
    rd_chk(4'h1, 16'h000A, "ext_cnt");
    // Active high on timer 1, compare starts the converter
    wr(4'h0, 16'h0142);
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0010);
    wr(4'h2, 16'h0008);
    wr(4'h4, ctl(gpt_pkg::MODE_CUP, 3'h0, gpt_pkg::SRC_INT, 1'b1, 1'b1));
    n_high = 0;
    n_adc = 0;
    repeat (34) begin
      @(posedge mclk);
      #1 n_high += cmp_pin[0];
      n_adc += adc_start;
    end
    chk("pin_active", 16'h0010, 16'(n_high));
    chk("adc_start", 16'h0002, 16'(n_adc));
    wr(4'h4, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h5, 16'h0000);
    wr(4'h8, ctl(gpt_pkg::MODE_CUP, 3'h0, gpt_pkg::SRC_INT, 1'b0, 1'b0) | 16'h0081);
    wr(4'h4, ctl(gpt_pkg::MODE_CUP, 3'h0, gpt_pkg::SRC_INT, 1'b1, 1'b0));
    repeat (40) @(posedge mclk);
    wr(4'h4, 16'h0000);
    rd_chk(4'h1, 16'h0008, "sync_t1");
    rd_chk(4'h5, 16'h0008, "sync_t2");
    give_verdict;
  end
endmodule
